// ---- src/hmws_pkg.sv ----
// Package with microword field layout, register map and sequencer states.
package hmws_pkg;
  localparam int CS_WIDTH         = 56;
  localparam int UW_WIDTH         = 48;
  localparam int CS_ADDR_WIDTH    = 10;
  localparam int ALU_HI           = 47;
  localparam int ALU_LO           = 44;
  localparam int LIT_HI           = 47;
  localparam int LIT_LO           = 40;
  localparam int DIR_HI           = 43;
  localparam int DIR_LO           = 32;
  localparam int ASRC_HI          = 31;
  localparam int ASRC_LO          = 27;
  localparam int BSRC_HI          = 26;
  localparam int BSRC_LO          = 22;
  localparam int DEST_HI          = 21;
  localparam int DEST_LO          = 17;
  localparam int PAIR_HI          = 16;
  localparam int PAIR_LO          = 15;
  localparam int STEER_BIT        = 14;
  localparam int LIT_EN_BIT       = 13;
  localparam int COND_HI          = 12;
  localparam int COND_LO          = 10;
  localparam int NEXT_HI          = 9;
  localparam int NEXT_LO          = 0;
  localparam logic [2:0] COND_NONE = 3'h0;
  localparam logic [7:0] APB_CTRL    = 8'h00;
  localparam logic [7:0] APB_START   = 8'h04;
  localparam logic [7:0] APB_STATUS  = 8'h08;
  localparam logic [7:0] APB_UW_LO   = 8'h0C;
  localparam logic [7:0] APB_UW_HI   = 8'h10;
  localparam int CTRL_RUN_BIT        = 0;
  localparam int STATUS_RUN_BIT      = 16;
  localparam logic [CS_ADDR_WIDTH-1:0] START_RESET = 10'h000;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10
  } hmws_state_type;
endpackage

// ---- src/hmws_field_decoder.sv ----
// One-hot decoder for an encoded microword field.
`timescale 1ns/10ps
`default_nettype none
module hmws_field_decoder
#(
  parameter int WIDTH = 4
)
(
  input  wire logic [WIDTH-1:0]      code,
  input  wire logic                  enable,
  output logic      [(1<<WIDTH)-1:0] onehot
);
  always_comb
  begin
    onehot = '0;
    if (enable)
    begin
      onehot[code] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- src/hmws_sequencer.sv ----
// Horizontal microword sequencer: fetch, branch, field decode and APB control.
// Overview of operation
// - Fetch and decode one 48-bit control word each microcycle.
// - Extended 56-bit store words: only the low 48 bits are decoded.
// - No microprogram counter; next address comes from the microword field.
// - A named branch condition is tested and may change the next fetch.
// - Microword explicitly carries two sources, result and next address.
// - Steering bit makes shared pair drive scratchpad writes or register clocks.
// - One microword bit may feed several control signals.
// - Literal and ALU function share bits; uses are mutually exclusive.
// - Most bits drive controls directly; encoded fields pass a decoder.
// - Fetched microword controls the datapath for its whole microcycle.
// - ALU function field is bits 47 to 44, sixteen distinct functions.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hmws_sequencer
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [7:0]                          paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  output logic      [hmws_pkg::CS_ADDR_WIDTH-1:0]  cs_addr,
  input  wire logic [hmws_pkg::CS_WIDTH-1:0]       cs_data,
  input  wire logic [7:0]                          cond_in,
  output logic                                     uword_active,
  output logic      [15:0]                         alu_sel,
  output logic      [7:0]                          literal,
  output logic                                     literal_valid,
  output logic      [11:0]                         direct_ctl,
  output logic      [4:0]                          a_src,
  output logic      [4:0]                          b_src,
  output logic      [4:0]                          dest,
  output logic      [1:0]                          sp_write,
  output logic      [1:0]                          reg_clock
);
  localparam int AW = hmws_pkg::CS_ADDR_WIDTH;

  hmws_pkg::hmws_state_type state_q;
  hmws_pkg::hmws_state_type state_d;
  logic [AW-1:0]     addr_q;
  logic [AW-1:0]     addr_d;
  logic [47:0]       uw_q;
  logic [47:0]       uw_d;
  logic              run_q;
  logic              run_d;
  logic [AW-1:0]     start_q;
  logic [AW-1:0]     start_d;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic              active_q;
  logic              active_d;
  logic [15:0]       alu_q;
  logic [15:0]       alu_d;
  logic [7:0]        lit_q;
  logic [7:0]        lit_d;
  logic              litv_q;
  logic              litv_d;
  logic [11:0]       dir_q;
  logic [11:0]       dir_d;
  logic [4:0]        asrc_q;
  logic [4:0]        asrc_d;
  logic [4:0]        bsrc_q;
  logic [4:0]        bsrc_d;
  logic [4:0]        dest_q;
  logic [4:0]        dest_d;
  logic [1:0]        spw_q;
  logic [1:0]        spw_d;
  logic [1:0]        rclk_q;
  logic [1:0]        rclk_d;
  logic [47:0]       fetched;
  logic [15:0]       alu_onehot;
  logic [7:0]        cond_onehot;
  logic              branch_taken;
  logic              apb_done;
  logic              apb_write;
  logic              is_lit;

  // The extension byte of wide store words carries no user meaning here.
  assign fetched = cs_data[hmws_pkg::UW_WIDTH-1:0];
  assign is_lit  = fetched[hmws_pkg::LIT_EN_BIT];

  // The literal enable bit also gates the ALU decode, so one bit steers two controls.
  hmws_field_decoder #(.WIDTH(4)) u_alu_dec
  (
    .code   (fetched[hmws_pkg::ALU_HI:hmws_pkg::ALU_LO]),
    .enable (!is_lit),
    .onehot (alu_onehot)
  );

  hmws_field_decoder #(.WIDTH(3)) u_cond_dec
  (
    .code   (uw_q[hmws_pkg::COND_HI:hmws_pkg::COND_LO]),
    .enable (uw_q[hmws_pkg::COND_HI:hmws_pkg::COND_LO] != hmws_pkg::COND_NONE),
    .onehot (cond_onehot)
  );

  // Condition code zero means no test, so its input line is never looked at.
  assign branch_taken = |(cond_onehot & cond_in);

  // Sequencing: fetch phase captures the word, exec phase holds it in control.
  always_comb
  begin
    state_d = state_q;
    addr_d  = addr_q;
    uw_d    = uw_q;
    case (state_q)
      hmws_pkg::ST_IDLE:
      begin
        if (run_q)
        begin
          addr_d  = start_q;
          state_d = hmws_pkg::ST_FETCH;
        end
      end
      hmws_pkg::ST_FETCH:
      begin
        uw_d    = fetched;
        state_d = hmws_pkg::ST_EXEC;
      end
      hmws_pkg::ST_EXEC:
      begin
        // Next address is explicit; a taken branch sets the low address bit.
        addr_d = uw_q[hmws_pkg::NEXT_HI:hmws_pkg::NEXT_LO] | {{(AW-1){1'b0}}, branch_taken};
        state_d = run_q ? hmws_pkg::ST_FETCH : hmws_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = hmws_pkg::ST_IDLE;
      end
    endcase
  end

  // Decoded controls are registered at the fetch edge and held for the microcycle.
  always_comb
  begin
    active_d = (state_q == hmws_pkg::ST_FETCH);
    alu_d    = alu_q;
    lit_d    = lit_q;
    litv_d   = litv_q;
    dir_d    = dir_q;
    asrc_d   = asrc_q;
    bsrc_d   = bsrc_q;
    dest_d   = dest_q;
    spw_d    = spw_q;
    rclk_d   = rclk_q;
    if (state_q == hmws_pkg::ST_FETCH)
    begin
      alu_d  = alu_onehot;
      lit_d  = is_lit ? fetched[hmws_pkg::LIT_HI:hmws_pkg::LIT_LO] : 8'h00;
      litv_d = is_lit;
      // Bits 43:40 are both literal bits and direct controls.
      dir_d  = fetched[hmws_pkg::DIR_HI:hmws_pkg::DIR_LO];
      asrc_d = fetched[hmws_pkg::ASRC_HI:hmws_pkg::ASRC_LO];
      bsrc_d = fetched[hmws_pkg::BSRC_HI:hmws_pkg::BSRC_LO];
      dest_d = fetched[hmws_pkg::DEST_HI:hmws_pkg::DEST_LO];
      spw_d  = fetched[hmws_pkg::STEER_BIT] ? 2'h0 : fetched[hmws_pkg::PAIR_HI:hmws_pkg::PAIR_LO];
      rclk_d = fetched[hmws_pkg::STEER_BIT] ? fetched[hmws_pkg::PAIR_HI:hmws_pkg::PAIR_LO] : 2'h0;
    end
    else if (state_q == hmws_pkg::ST_IDLE)
    begin
      // Stopped: strobes drop so no stale word keeps writing the datapath.
      spw_d  = 2'h0;
      rclk_d = 2'h0;
    end
  end

  // APB slave: one wait state, then a registered answer.
  assign apb_done  = psel && penable && pready_q;
  assign apb_write = apb_done && pwrite;

  always_comb
  begin
    run_d     = run_q;
    start_d   = start_q;
    pready_d  = psel && penable && !pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q)
    begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        hmws_pkg::APB_CTRL:   prdata_d[hmws_pkg::CTRL_RUN_BIT] = run_q;
        hmws_pkg::APB_START:  prdata_d[AW-1:0] = start_q;
        hmws_pkg::APB_STATUS:
        begin
          prdata_d[AW-1:0] = addr_q;
          prdata_d[hmws_pkg::STATUS_RUN_BIT] = (state_q != hmws_pkg::ST_IDLE);
        end
        hmws_pkg::APB_UW_LO:  prdata_d = uw_q[31:0];
        hmws_pkg::APB_UW_HI:  prdata_d[15:0] = uw_q[47:32];
        default:              pslverr_d = 1'b1;
      endcase
      if (pwrite)
      begin
        prdata_d = 32'h0000_0000;
      end
    end
    if (apb_write)
    begin
      if (paddr == hmws_pkg::APB_CTRL)
      begin
        run_d = pwdata[hmws_pkg::CTRL_RUN_BIT];
      end
      if (paddr == hmws_pkg::APB_START)
      begin
        start_d = pwdata[AW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= hmws_pkg::ST_IDLE;
      addr_q    <= hmws_pkg::START_RESET;
      uw_q      <= 48'h0000_0000_0000;
      run_q     <= 1'b0;
      start_q   <= hmws_pkg::START_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      active_q  <= 1'b0;
      alu_q     <= 16'h0000;
      lit_q     <= 8'h00;
      litv_q    <= 1'b0;
      dir_q     <= 12'h000;
      asrc_q    <= 5'h00;
      bsrc_q    <= 5'h00;
      dest_q    <= 5'h00;
      spw_q     <= 2'h0;
      rclk_q    <= 2'h0;
    end
    else
    begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      uw_q      <= uw_d;
      run_q     <= run_d;
      start_q   <= start_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      active_q  <= active_d;
      alu_q     <= alu_d;
      lit_q     <= lit_d;
      litv_q    <= litv_d;
      dir_q     <= dir_d;
      asrc_q    <= asrc_d;
      bsrc_q    <= bsrc_d;
      dest_q    <= dest_d;
      spw_q     <= spw_d;
      rclk_q    <= rclk_d;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign cs_addr       = addr_q;
  assign uword_active  = active_q;
  assign alu_sel       = alu_q;
  assign literal       = lit_q;
  assign literal_valid = litv_q;
  assign direct_ctl    = dir_q;
  assign a_src         = asrc_q;
  assign b_src         = bsrc_q;
  assign dest          = dest_q;
  assign sp_write      = spw_q;
  assign reg_clock     = rclk_q;
endmodule
`default_nettype wire

// ---- sim/hmws_sequencer_props.sv ----
// Assertion checker for the microword sequencer ports.
`timescale 1ns/10ps
`default_nettype none
module hmws_sequencer_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [9:0]  cs_addr,
  input wire logic [55:0] cs_data,
  input wire logic [7:0]  cond_in,
  input wire logic        uword_active,
  input wire logic [15:0] alu_sel,
  input wire logic [7:0]  literal,
  input wire logic        literal_valid,
  input wire logic [11:0] direct_ctl,
  input wire logic [4:0]  a_src,
  input wire logic [4:0]  b_src,
  input wire logic [4:0]  dest,
  input wire logic [1:0]  sp_write,
  input wire logic [1:0]  reg_clock
);
  logic [9:0] next_q;
  logic [9:0] next_d;
  logic       taken;
  // The store answers combinationally, so cs_data still shows the fetched word in the exec cycle.
  always_comb
  begin
    taken = (cs_data[12:10] != 3'h0) && cond_in[cs_data[12:10]];
    next_d = uword_active ? (cs_data[9:0] | {9'h000, taken}) : next_q;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      next_q <= 10'h000;
    else
      next_q <= next_d;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_fields_direct: assert property (
    uword_active |-> a_src == cs_data[31:27] && b_src == cs_data[26:22]
      && dest == cs_data[21:17] && direct_ctl == cs_data[43:32]) else $error("field mismatch");
  a_steer_pair: assert property (
    uword_active |-> sp_write == (cs_data[14] ? 2'h0 : cs_data[16:15])
      && reg_clock == (cs_data[14] ? cs_data[16:15] : 2'h0)) else $error("pair mismatch");
  a_literal_share: assert property (
    uword_active |-> literal_valid == cs_data[13]
      && literal == (cs_data[13] ? cs_data[47:40] : 8'h00)) else $error("literal mismatch");
  a_alu_decode: assert property (
    uword_active |-> alu_sel == (cs_data[13] ? 16'h0000 : 16'h0001 << cs_data[47:44]))
    else $error("alu select mismatch");
  a_one_fetch: assert property (
    uword_active |=> !uword_active) else $error("exec pulse too long");
  a_hold_cycle: assert property (
    uword_active |=> $stable(alu_sel) && $stable(literal) && $stable(dest))
    else $error("controls changed mid microcycle");
  a_addr_stable: assert property (
    uword_active |-> $stable(cs_addr)) else $error("address moved in microcycle");
  a_next_addr: assert property (
    uword_active ##2 uword_active |-> cs_addr == next_q) else $error("wrong next address");
endmodule
bind hmws_sequencer hmws_sequencer_props i_props
(
  .pclk, .presetn, .cs_addr, .cs_data, .cond_in, .uword_active, .alu_sel, .literal,
  .literal_valid, .direct_ctl, .a_src, .b_src, .dest, .sp_write, .reg_clock
);
`default_nettype wire

// ---- sim/hmws_store_model.sv ----
// Behavioural control store that answers a fetch combinationally.
`timescale 1ns/10ps
`default_nettype none
module hmws_store_model
(
  input  wire logic [9:0]  addr,
  output logic      [55:0] data
);
  // Full 56-bit words; the top 8 extension bits must not reach the decode.
  logic [55:0] mem [0:1023];
  assign data = mem[addr];
endmodule
`default_nettype wire

// ---- sim/test_hmws_sequencer.sv ----
// Self-checking bench for the microword sequencer.
`timescale 1ns/10ps
`default_nettype none
module test_hmws_sequencer;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  cs_addr;
  logic [55:0] cs_data;
  logic [7:0]  cond_in;
  logic        uword_active;
  logic [15:0] alu_sel;
  logic [4:0]  dest;
  logic [1:0]  sp_write;
  logic [1:0]  reg_clock;
  logic [31:0] rd;
  logic        er;
  logic [9:0]  ea;
  logic [55:0] uw;
  int          errors;
  int          samples_checked;
  int          i;
  int          n;
  int          k;
  hmws_sequencer i_dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cs_addr, .cs_data, .cond_in, .uword_active, .alu_sel, .literal (),
    .literal_valid (), .direct_ctl (), .a_src (), .b_src (), .dest, .sp_write, .reg_clock
  );
  hmws_store_model i_store (.addr (cs_addr), .data (cs_data));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compared %0d values, %0d wrong", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Holds the whole request until pready is seen high, then releases it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 8 && pready !== 1'b1; t++)
      @(posedge pclk);
    if (t == 8)
    begin
      errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Word w sits at w*32 and names word (w+1) mod 17, so flow ignores storage order.
  function automatic logic [55:0] word(input int w);
    return {8'hA5, 4'(w), 12'(w * 291), 5'(w), 5'(w + 3), 5'(w + 1), 2'(w), w[0], w == 16,
            3'(w), 10'((w + 1) % 17 * 32)};
  endfunction
  initial
  begin
    errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cond_in = 8'h5A;
    repeat (16) @(posedge pclk);
    for (i = 0; i < 1024; i++)
      i_store.mem[i] = {28{i[0], ~i[0]}};
    for (i = 0; i < 17; i++)
    begin
      i_store.mem[i * 32] = word(i);
      i_store.mem[i * 32 + 1] = word(i);
    end
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0000_0000);
    check("status", rd, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0020);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check("start", rd, 32'h0000_0020);
    check("start error", er, 1'b0);
    apb(1'b0, 8'h14, 32'h0000_0000);
    check("unmapped error", er, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_0000);
    check("unmapped write error", er, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0001);
    ea = 10'h020;
    for (n = 0; n < 20; n++)
    begin
      i = (n + 1) % 17;
      @(negedge pclk);
      for (k = 0; k < 8 && uword_active !== 1'b1; k++)
        @(negedge pclk);
      if (k == 8)
      begin
        errors++;
        conclude();
      end
      check("fetch address", cs_addr, ea);
      check("alu select", alu_sel, i == 16 ? 0 : 1 << i);
      check("result field", dest, i + 1);
      check("pair", {sp_write, reg_clock}, i[0] ? i % 4 : i % 4 * 4);
      ea = 10'((i + 1) % 17 * 32) | 10'(i % 8 != 0 && cond_in[i % 8]);
    end
    apb(1'b0, hmws_pkg::APB_CTRL, 32'h0000_0000);
    check("run bit", rd, 32'h0000_0001);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check("running", rd[16], 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check("stopped", rd[16], 1'b0);
    // Stopped address names the successor, so the held word is the one before it.
    n = (rd[9:5] + 16) % 17;
    uw = word(n);
    apb(1'b0, hmws_pkg::APB_UW_LO, 32'h0000_0000);
    check("word low", rd, uw[31:0]);
    apb(1'b0, hmws_pkg::APB_UW_HI, 32'h0000_0000);
    check("word high", rd, {16'h0000, uw[47:32]});
    conclude();
  end
endmodule
`default_nettype wire
